/* File: hw/scss_top.sv */
// Contract
// - Three-bit configuration field picks one of eight clock and pin modes.
// - Logic-clock mode clocks from input pin; second pin is general I/O.
// - RC mode drives clock divided by four on second pin; RC-I/O frees it.
// - Internal clock-out mode outputs divided clock; first pin is general I/O.
// - Internal I/O mode frees both oscillator pins.
// - Three crystal modes: low power, medium gain, high gain drive.
// - Fail-safe monitor detects lost external clock and switches to internal.
// - Frequency field maps 111..001 to 8 MHz..125 kHz, 000 to 31 kHz.
// - Frequency field resets to 110 and is software read/write.
// - Start-up status reads 1 on configured clock, 0 on internal.
// - Start-up status resets 0 with two-speed crystal, fail-safe or an internal mode, else 1.
// - High-frequency stable bit shows stability, resets to 0.
// - Low-frequency stable bit shows stability, resets to 0.
// - Clock select bit set routes internal oscillator; resets to 0.
// - Two internal oscillators: calibrated 8 MHz and uncalibrated 31 kHz.
// - Two-speed start-up runs internal clock while external one starts.
// - Crystal modes count 1024 oscillator cycles before execution proceeds on the crystal.
// - Logic-clock mode skips the start-up count.
//
// Purpose: System clock source selection, start-up timing and fail-safe switch.
// Assumes: Oscillator levels are sampled by core_clk; config word is static after reset.
// Notes: Produces a gated clock enable level sys_clk_level, not a real clock net.
//
// Decided for this implementation: the address map and the strobed register port.
`default_nettype none

module scss_top
    import scss_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [2:0] config_clock_mode,
    input wire logic config_two_speed,
    input wire logic config_failsafe,
    input wire logic wake_pulse,
    input wire logic osc_pin_in,
    input wire logic hf_internal_oscillator,
    input wire logic lf_internal_oscillator,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic irq,
    output logic sys_clk_level,
    output logic run_enable,
    output logic osc_pin_out,
    output logic osc_pin_out_oe,
    output logic osc_pin_in_gpio,
    output logic osc_pin_out_gpio,
    output logic [1:0] amp_gain,
    output logic amp_enable
);
    scss_osc_if osc();

    scss_osc_monitor u_mon (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ext_level(osc_pin_in),
        .hf_level(hf_internal_oscillator),
        .lf_level(lf_internal_oscillator),
        .osc(osc)
    );

    // ==========================================================
    // State
    typedef struct packed {
        scss_state_t fsm;
        logic [2:0] internal_freq_select;
        logic system_clock_select;
        logic on_internal;
        logic failed;
        logic [10:0] startup_cnt;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic [7:0] rdata;
        logic [6:0] div_cnt;
        logic int_clk;
        logic [1:0] q_cnt;
        logic clkout;
        logic sys_clk;
        logic want_internal;
        logic started;
        logic armed;
    } scss_top_t;

    scss_top_t st_reg;
    scss_top_t st_next;
    scss_mode_t mode;
    logic is_crystal;
    logic is_internal_mode;
    logic ext_clk_mode;
    logic need_startup;
    logic target_internal;
    logic cur_src;
    logic new_src;
    logic src_rise;
    logic [6:0] div_half;
    logic [7:0] ctrl_val;
    logic [7:0] irq_set;

    assign mode = scss_mode_t'(config_clock_mode);
    assign is_crystal = (mode == SCSS_LOW_POWER_CRYSTAL_MODE) || (mode == SCSS_MEDIUM_GAIN_CRYSTAL_MODE)
        || (mode == SCSS_HIGH_GAIN_CRYSTAL_MODE);
    assign is_internal_mode = (mode == SCSS_INTERNAL_IO_MODE) || (mode == SCSS_INTERNAL_WITH_CLOCKOUT_MODE);
    assign ext_clk_mode = !is_internal_mode;
    assign need_startup = is_crystal;
    // Fail-safe forces internal once the external clock is lost
    assign target_internal = is_internal_mode || st_reg.system_clock_select || st_reg.failed
        || !st_reg.started;

    // ==========================================================
    // Half period in HF rising edges, minus one; select 111 passes the HF level straight through
    always_comb begin
        case (st_reg.internal_freq_select)
            3'h7: div_half = 7'h00;
            3'h6: div_half = 7'h00;
            3'h5: div_half = 7'h01;
            3'h4: div_half = 7'h03;
            3'h3: div_half = 7'h07;
            3'h2: div_half = 7'h0f;
            3'h1: div_half = 7'h1f;
            default: div_half = 7'h00;
        endcase
    end

    // Internal clock level: LF oscillator directly at select 000
    assign cur_src = st_reg.on_internal ? st_reg.int_clk : osc_pin_in;
    assign new_src = st_reg.want_internal ? st_reg.int_clk : osc_pin_in;

    assign ctrl_val = {1'b0, st_reg.internal_freq_select, !st_reg.on_internal,
        osc.hf_stable, osc.lf_stable, st_reg.system_clock_select};

    always_comb begin
        irq_set = '0;
        irq_set[SCSS_IRQ_FAIL] = osc.ext_lost && config_failsafe && ext_clk_mode && !st_reg.failed;
        irq_set[SCSS_IRQ_STARTED] = (st_reg.fsm == SCSS_ST_STARTUP) && (st_reg.startup_cnt == '0);
        irq_set[SCSS_IRQ_HF_STABLE] = osc.hf_stable && !st_reg.armed;
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.rdata = '0;
        st_next.armed = st_reg.armed | osc.hf_stable;
        // Internal clock generation
        if (st_reg.internal_freq_select == SCSS_FREQ_LF) begin
            st_next.int_clk = lf_internal_oscillator;
            st_next.div_cnt = '0;
        end else if (st_reg.internal_freq_select == SCSS_FREQ_MAX) begin
            st_next.int_clk = hf_internal_oscillator;
            st_next.div_cnt = '0;
        end else if (osc.hf_rise) begin
            if (st_reg.div_cnt >= div_half) begin
                st_next.div_cnt = '0;
                st_next.int_clk = !st_reg.int_clk;
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 7'h01;
            end
        end
        // Fail-safe latch
        if (config_failsafe && ext_clk_mode && osc.ext_lost) begin
            st_next.failed = 1'b1;
        end
        // Glitch-free handover: leave old source low, join new source low
        case (st_reg.fsm)
            SCSS_ST_RUN: begin
                st_next.sys_clk = cur_src;
                if (target_internal != st_reg.on_internal) begin
                    st_next.want_internal = target_internal;
                    st_next.fsm = SCSS_ST_WAIT_OLD_LOW;
                end
            end
            SCSS_ST_WAIT_OLD_LOW: begin
                st_next.sys_clk = cur_src & st_reg.sys_clk;
                // A dead source may be stuck high, so after a loss it is cut at once
                if (!cur_src || st_reg.failed) begin
                    st_next.sys_clk = 1'b0;
                    st_next.fsm = SCSS_ST_WAIT_NEW_LOW;
                end
            end
            SCSS_ST_WAIT_NEW_LOW: begin
                st_next.sys_clk = 1'b0;
                if (!new_src) begin
                    st_next.on_internal = st_reg.want_internal;
                    st_next.fsm = SCSS_ST_RUN;
                end
            end
            SCSS_ST_STARTUP: begin
                st_next.sys_clk = cur_src;
                if (osc.ext_rise && st_reg.startup_cnt != '0) begin
                    st_next.startup_cnt = st_reg.startup_cnt - 11'h001;
                end
                if (st_reg.startup_cnt == '0) begin
                    st_next.started = 1'b1;
                    st_next.fsm = SCSS_ST_RUN;
                end
            end
            default: begin
                st_next.fsm = SCSS_ST_RUN;
            end
        endcase
        // Wake from sleep restarts the crystal count
        if (wake_pulse && need_startup) begin
            st_next.started = 1'b0;
            st_next.startup_cnt = SCSS_STARTUP_OSC_CYCLES;
            st_next.fsm = SCSS_ST_STARTUP;
        end
        // Clock-out divides the running source by four
        src_rise = st_reg.on_internal ? (st_next.int_clk && !st_reg.int_clk) : osc.ext_rise;
        if (src_rise) begin
            st_next.q_cnt = st_reg.q_cnt + 2'h1;
            if (st_reg.q_cnt[0]) begin
                st_next.clkout = !st_reg.clkout;
            end
        end
        // Register bus; set wins over write-one clear
        st_next.irq_stat = st_reg.irq_stat | irq_set;
        if (reg_write) begin
            case (reg_addr)
                SCSS_OFS_CTRL: begin
                    st_next.internal_freq_select = reg_wdata[SCSS_FREQ_LSB +: 3];
                    st_next.system_clock_select = reg_wdata[SCSS_CLKSEL_BIT];
                end
                SCSS_OFS_IRQ_STAT: st_next.irq_stat = (st_reg.irq_stat & ~reg_wdata) | irq_set;
                SCSS_OFS_IRQ_MASK: st_next.irq_mask = reg_wdata;
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                SCSS_OFS_CTRL: st_next.rdata = ctrl_val;
                SCSS_OFS_IRQ_STAT: st_next.rdata = st_reg.irq_stat;
                SCSS_OFS_IRQ_MASK: st_next.rdata = st_reg.irq_mask;
                SCSS_OFS_MODE: st_next.rdata = {5'h00, config_clock_mode};
                default: st_next.rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // Registers and reset-time strap capture
    logic boot_done_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.fsm <= SCSS_ST_RUN;
            st_reg.internal_freq_select <= SCSS_FREQ_RESET;
            st_reg.irq_stat <= SCSS_IRQ_RESET;
            st_reg.irq_mask <= SCSS_IRQ_RESET;
            st_reg.on_internal <= 1'b1;
            boot_done_reg <= 1'b0;
        end else if (!boot_done_reg) begin
            // Straps are read on the first edge after release
            boot_done_reg <= 1'b1;
            st_reg <= st_next;
            st_reg.started <= !need_startup || !(config_two_speed || config_failsafe) ? 1'b1 : 1'b0;
            st_reg.startup_cnt <= SCSS_STARTUP_OSC_CYCLES;
            st_reg.fsm <= need_startup ? SCSS_ST_STARTUP : SCSS_ST_RUN;
            st_reg.on_internal <= is_internal_mode
                || (need_startup && config_two_speed) || config_failsafe;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs and pin usage
    assign reg_rdata = st_reg.rdata;
    assign irq = |(st_reg.irq_stat & st_reg.irq_mask);
    assign sys_clk_level = st_reg.sys_clk;
    // Execution halts during a start-up count unless running on the internal clock
    assign run_enable = boot_done_reg && !((st_reg.fsm == SCSS_ST_STARTUP) && !st_reg.on_internal);
    assign osc_pin_out = st_reg.clkout;
    assign osc_pin_out_oe = (mode == SCSS_RC_MODE) || (mode == SCSS_INTERNAL_WITH_CLOCKOUT_MODE);
    assign osc_pin_in_gpio = is_internal_mode;
    assign osc_pin_out_gpio = (mode == SCSS_EXTERNAL_LOGIC_CLOCK_MODE) || (mode == SCSS_RC_WITH_IO_MODE)
        || (mode == SCSS_INTERNAL_IO_MODE);
    assign amp_enable = is_crystal;
    assign amp_gain = is_crystal ? config_clock_mode[1:0] : 2'h0;

    // ==========================================================
    // Checks
    reg_reset_a: assert property (@(posedge core_clk) $rose(arst_n) |->
        ctrl_val[SCSS_FREQ_LSB +: 3] == SCSS_FREQ_RESET && !ctrl_val[SCSS_CLKSEL_BIT])
        else $error("frequency or select field wrong after reset");
    startup_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(st_reg.fsm == SCSS_ST_RUN) && $past(ctrl_val[SCSS_STARTUP_BIT])
        |-> sys_clk_level == $past(osc_pin_in))
        else $error("start-up status set while system clock not from pin");
    hf_stable_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !$fell(ctrl_val[SCSS_HF_STABLE_BIT]))
        else $error("hf stable bit dropped");
    lf_stable_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(ctrl_val[SCSS_LF_STABLE_BIT]) |-> $past(lf_internal_oscillator))
        else $error("lf stable bit set without an oscillator edge");
    clkout_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (mode == SCSS_RC_WITH_IO_MODE || mode == SCSS_EXTERNAL_LOGIC_CLOCK_MODE) |-> !osc_pin_out_oe)
        else $error("clock out driven in an I/O mode");
    failsafe_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (boot_done_reg && config_failsafe && ext_clk_mode && osc.ext_lost) |-> ##[1:20] st_reg.on_internal)
        else $error("no switch to internal after clock loss");
    no_runt_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (st_reg.fsm == SCSS_ST_WAIT_NEW_LOW) |-> !sys_clk_level)
        else $error("clock high during handover");
    select_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(st_reg.system_clock_select) && st_reg.started |-> ##[1:300] st_reg.on_internal)
        else $error("select bit did not reach internal source");
    ext_no_wait_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (boot_done_reg && mode == SCSS_EXTERNAL_LOGIC_CLOCK_MODE) |-> run_enable)
        else $error("logic-clock mode stalled for start-up");
endmodule : scss_top

`default_nettype wire

/* File: hw/scss_pkg.sv */
// Purpose: Shared constants and types for the system clock source select block.
// Assumes: One core clock at 100 MHz; oscillator inputs sampled as plain levels.
// Notes: Register offset and interrupt layout are local choices.
`default_nettype none

package scss_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] SCSS_OFS_CTRL = 4'h0;
    localparam logic [3:0] SCSS_OFS_IRQ_STAT = 4'h1;
    localparam logic [3:0] SCSS_OFS_IRQ_MASK = 4'h2;
    localparam logic [3:0] SCSS_OFS_MODE = 4'h3;
    // Control register fields
    localparam int SCSS_FREQ_LSB = 4;
    localparam int SCSS_STARTUP_BIT = 3;
    localparam int SCSS_HF_STABLE_BIT = 2;
    localparam int SCSS_LF_STABLE_BIT = 1;
    localparam int SCSS_CLKSEL_BIT = 0;
    localparam logic [2:0] SCSS_FREQ_RESET = 3'h6;
    localparam logic [2:0] SCSS_FREQ_LF = 3'h0;
    localparam logic [2:0] SCSS_FREQ_MAX = 3'h7;
    // Interrupt status bits
    localparam int SCSS_IRQ_FAIL = 0;
    localparam int SCSS_IRQ_STARTED = 1;
    localparam int SCSS_IRQ_HF_STABLE = 2;
    localparam logic [7:0] SCSS_IRQ_RESET = 8'h00;
    // ==========================================================
    // Timing
    localparam logic [10:0] SCSS_STARTUP_OSC_CYCLES = 11'h400;
    localparam int SCSS_CORE_MHZ = 100;
    localparam int SCSS_FAIL_TIME_US = 40;
    localparam logic [12:0] SCSS_FAIL_CYCLES = 13'(SCSS_FAIL_TIME_US * SCSS_CORE_MHZ);
    localparam int SCSS_STABLE_EDGES = 8;
    localparam logic [3:0] SCSS_STABLE_EDGES_W = 4'h8;

    // ==========================================================
    // Clock modes in the configuration word
    typedef enum logic [2:0] {
        SCSS_LOW_POWER_CRYSTAL_MODE = 3'h0,
        SCSS_MEDIUM_GAIN_CRYSTAL_MODE = 3'h1,
        SCSS_HIGH_GAIN_CRYSTAL_MODE = 3'h2,
        SCSS_EXTERNAL_LOGIC_CLOCK_MODE = 3'h3,
        SCSS_INTERNAL_IO_MODE = 3'h4,
        SCSS_INTERNAL_WITH_CLOCKOUT_MODE = 3'h5,
        SCSS_RC_WITH_IO_MODE = 3'h6,
        SCSS_RC_MODE = 3'h7
    } scss_mode_t;

    // Source switch states, one-hot
    typedef enum logic [3:0] {
        SCSS_ST_RUN = 4'h1,
        SCSS_ST_WAIT_OLD_LOW = 4'h2,
        SCSS_ST_WAIT_NEW_LOW = 4'h4,
        SCSS_ST_STARTUP = 4'h8
    } scss_state_t;
endpackage : scss_pkg

`default_nettype wire

/* File: hw/scss_osc_if.sv */
// Purpose: Carries oscillator rising edges, loss and stability from the monitor to the top.
// Assumes: All signals are in the core clock domain.
// Notes: One producer (monitor), one consumer (top).
`default_nettype none

interface scss_osc_if;
    logic ext_rise;
    logic ext_lost;
    logic hf_stable;
    logic lf_stable;
    logic hf_rise;
    modport mon (output ext_rise, output ext_lost, output hf_stable, output lf_stable, output hf_rise);
    modport top (input ext_rise, input ext_lost, input hf_stable, input lf_stable, input hf_rise);
endinterface : scss_osc_if

`default_nettype wire

/* File: hw/scss_osc_monitor.sv */
// Purpose: Watches the external and internal oscillator levels for edges, and the external one for loss.
// Assumes: Oscillator levels arrive as core-clock-synchronous inputs.
// Notes: Stability is declared after a fixed number of clean rising edges.
`default_nettype none

module scss_osc_monitor
    import scss_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ext_level,
    input wire logic hf_level,
    input wire logic lf_level,
    scss_osc_if.mon osc
);
    typedef struct packed {
        logic ext_d;
        logic hf_d;
        logic lf_d;
        logic [12:0] idle_cnt;
        logic [3:0] hf_edges;
        logic [3:0] lf_edges;
    } scss_mon_t;

    scss_mon_t st_reg;
    scss_mon_t st_next;
    logic ext_rise;
    logic hf_rise;
    logic lf_rise;

    assign ext_rise = ext_level & ~st_reg.ext_d;
    assign hf_rise = hf_level & ~st_reg.hf_d;
    assign lf_rise = lf_level & ~st_reg.lf_d;

    always_comb begin
        st_next = st_reg;
        st_next.ext_d = ext_level;
        st_next.hf_d = hf_level;
        st_next.lf_d = lf_level;
        // Loss of clock: no external edge for a whole window
        if (ext_rise) begin
            st_next.idle_cnt = '0;
        end else if (st_reg.idle_cnt != SCSS_FAIL_CYCLES) begin
            st_next.idle_cnt = st_reg.idle_cnt + 13'h0001;
        end
        if (hf_rise && st_reg.hf_edges != SCSS_STABLE_EDGES_W) begin
            st_next.hf_edges = st_reg.hf_edges + 4'h1;
        end
        if (lf_rise && st_reg.lf_edges != SCSS_STABLE_EDGES_W) begin
            st_next.lf_edges = st_reg.lf_edges + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign osc.ext_rise = ext_rise;
    assign osc.hf_rise = hf_rise;
    assign osc.ext_lost = (st_reg.idle_cnt == SCSS_FAIL_CYCLES);
    assign osc.hf_stable = (st_reg.hf_edges == SCSS_STABLE_EDGES_W);
    assign osc.lf_stable = (st_reg.lf_edges == SCSS_STABLE_EDGES_W);
endmodule : scss_osc_monitor

`default_nettype wire

/* File: verif/scss_osc_model.sv */
// Purpose: Far-side oscillators: external source plus both internal oscillators.
// Assumes: Levels change right after core_clk rises.
// Notes: A stopped oscillator holds its level, as a dead crystal would.
`default_nettype none

module scss_osc_model #(
    parameter int EXT_HALF = 2,
    parameter int LF_HALF = 8
) (
    input wire logic core_clk,
    input wire logic ext_run,
    input wire logic int_run,
    output logic ext_level,
    output logic hf_level,
    output logic lf_level
);
    timeunit 1ns;
    timeprecision 1ns;
    int ext_cnt = 0;
    int lf_cnt = 0;
    initial begin
        ext_level = 1'b0;
        hf_level = 1'b0;
        lf_level = 1'b0;
    end
    // ==========================================================
    // Oscillation, fastest internal source toggles every cycle
    always @(posedge core_clk) begin
        if (ext_run) begin
            ext_cnt <= (ext_cnt + 1) % EXT_HALF;
            if (ext_cnt == EXT_HALF - 1) ext_level <= ~ext_level;
        end
        if (int_run) begin
            hf_level <= ~hf_level;
            lf_cnt <= (lf_cnt + 1) % LF_HALF;
            if (lf_cnt == LF_HALF - 1) lf_level <= ~lf_level;
        end
    end
endmodule : scss_osc_model

`default_nettype wire

/* File: verif/tb_system_clock_source_select.sv */
// Purpose: Self-checking bench for the clock source select block.
// Assumes: Straps change only while reset is held.
// Notes: Rates are judged by edge counts with a tolerance of one.
`default_nettype none

module tb_system_clock_source_select
    import scss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] mode = 3'h0;
    logic ts = 1'b0;
    logic fs = 1'b0;
    logic wake = 1'b0;
    logic ext_run = 1'b0;
    logic int_run = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext_l, hf_l, lf_l, irq, sys_clk, run_en, out, out_oe, in_gpio, out_gpio, amp_en;
    logic [1:0] gain;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [2:0] f;
    logic [4:0] prev = 5'h00;
    int failures = 0;
    int cmp_count = 0;
    int n_ext = 0;
    int n_hf = 0;
    int n_lf = 0;
    int n_out = 0;
    int n_sys = 0;

    initial forever #5 core_clk = ~core_clk;

    scss_osc_model osc (.core_clk(core_clk), .ext_run(ext_run), .int_run(int_run),
        .ext_level(ext_l), .hf_level(hf_l), .lf_level(lf_l));

    scss_top dut (.core_clk(core_clk), .arst_n(arst_n), .config_clock_mode(mode),
        .config_two_speed(ts), .config_failsafe(fs), .wake_pulse(wake), .osc_pin_in(ext_l),
        .hf_internal_oscillator(hf_l), .lf_internal_oscillator(lf_l), .reg_addr(addr),
        .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata), .irq(irq),
        .sys_clk_level(sys_clk), .run_enable(run_en), .osc_pin_out(out), .osc_pin_out_oe(out_oe),
        .osc_pin_in_gpio(in_gpio), .osc_pin_out_gpio(out_gpio), .amp_gain(gain), .amp_enable(amp_en));

    always @(posedge core_clk) begin
        prev <= {ext_l, hf_l, lf_l, out, sys_clk};
        if (ext_l && !prev[4]) n_ext++;
        if (hf_l && !prev[3]) n_hf++;
        if (lf_l && !prev[2]) n_lf++;
        if (out && !prev[1]) n_out++;
        if (sys_clk && !prev[0]) n_sys++;
    end

    // ==========================================================
    // Expectations
    function automatic logic [5:0] pins(input logic [2:0] m);
        pins = {m == 3'h5 || m == 3'h7, m == 3'h4 || m == 3'h5,
            m == 3'h3 || m == 3'h4 || m == 3'h6, m < 3'h3, m < 3'h3 ? m[1:0] : 2'h0};
    endfunction : pins

    function automatic logic [7:0] ctrl_rst(input logic [2:0] m, input logic t, input logic s);
        ctrl_rst = {1'b0, 3'h6, !((m < 3'h3 && t) || s || m == 3'h4 || m == 3'h5), 3'h0};
    endfunction : ctrl_rst

    function automatic int src(input int s);
        return s == 0 ? n_ext : (s == 1 ? n_hf : n_lf);
    endfunction : src

    // ==========================================================
    // Bus and check tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic rst(input logic [2:0] m, input logic t, input logic s);
        @(posedge core_clk);
        arst_n <= 1'b0;
        ext_run <= 1'b0;
        int_run <= 1'b0;
        mode <= m;
        ts <= t;
        fs <= s;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask : rst

    task automatic osc_on(input int n);
        ext_run <= 1'b1;
        int_run <= 1'b1;
        repeat (n) @(posedge core_clk);
    endtask : osc_on

    task automatic wait_run(input int lim);
        for (int i = 0; i < lim && run_en !== 1'b1; i++) @(posedge core_clk);
        #1;
        chk("run_enable", 1'b1, run_en);
    endtask : wait_run

    // Window after a settle time, so a source handover never lands inside it
    task automatic meas(input int sel, input int sh);
        int s0;
        int o0;
        int e;
        int y0;
        repeat (600) @(posedge core_clk);
        s0 = src(sel);
        o0 = n_out;
        y0 = n_sys;
        repeat (4096) @(posedge core_clk);
        e = (src(sel) - s0) >>> sh;
        o0 = n_out - o0;
        chk("clkout rate", 16'(e), (o0 - e <= 1 && e - o0 <= 1) ? 16'(e) : 16'(o0));
        y0 = (n_sys - y0) >>> 2;
        chk("sys clock rate", 16'(e), (y0 - e <= 1 && e - y0 <= 1) ? 16'(e) : 16'(y0));
    endtask : meas

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #1_000_000;
        failures++;
        wrap_up();
    end

    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(32'h0ea1));
        for (int m = 0; m < 8; m++) begin
            rst(3'(m), m == 0, m == 1 || m == 7);
            chk("pins", pins(3'(m)), {out_oe, in_gpio, out_gpio, amp_en, gain});
            if (m == 2 || m == 3) chk("run_enable", m == 3, run_en);
            rd_reg(SCSS_OFS_CTRL);
            chk("ctrl reset", ctrl_rst(3'(m), m == 0, m == 1 || m == 7), d);
            rd_reg(SCSS_OFS_MODE);
            chk("mode", {5'h00, 3'(m)}, d);
        end
        rst(3'h3, 1'b0, 1'b0);
        osc_on(300);
        rd_reg(SCSS_OFS_IRQ_STAT);
        chk("hf event", 8'h04, d);
        #10 chk("irq masked", 1'b0, irq);
        wr_reg(SCSS_OFS_IRQ_MASK, 8'h04);
        repeat (2) @(posedge core_clk);
        #1 chk("irq", 1'b1, irq);
        wr_reg(SCSS_OFS_IRQ_STAT, 8'h04);
        rd_reg(SCSS_OFS_IRQ_STAT);
        chk("irq clear", 8'h00, d);
        #10 chk("irq low", 1'b0, irq);
        for (int i = 0; i < 8; i++) begin
            f = 3'($urandom);
            wr_reg(SCSS_OFS_CTRL, {1'($urandom), f, 3'($urandom), 1'b0});
            wr_reg(4'(4 + $urandom % 12), 8'hff);
            rd_reg(SCSS_OFS_CTRL);
            chk("ctrl rw", {1'b0, f, 4'he}, d);
            rd_reg(4'(4 + $urandom % 12));
            chk("unmapped", 8'h00, d);
        end
        #10 chk("rdata idle", 8'h00, rdata);
        for (int s = 1; s >= 0; s--) begin
            wr_reg(SCSS_OFS_CTRL, {4'h7, 3'h0, 1'(s)});
            repeat (300) @(posedge core_clk);
            rd_reg(SCSS_OFS_CTRL);
            chk("select", {4'h7, 1'(!s), 2'h3, 1'(s)}, d);
        end
        rst(3'h5, 1'b0, 1'b0);
        osc_on(300);
        for (int c = 0; c < 8; c++) begin
            wr_reg(SCSS_OFS_CTRL, {1'b0, 3'(c), 4'h0});
            meas(c == 0 ? 2 : 1, c == 0 ? 2 : 9 - c);
        end
        rst(3'h7, 1'b0, 1'b0);
        osc_on(10);
        meas(0, 2);
        // Crystal with no two-speed: held until the start-up count ends
        rst(3'h1, 1'b0, 1'b0);
        osc_on(4000);
        #1 chk("run hold", 1'b0, run_en);
        wait_run(600);
        rd_reg(SCSS_OFS_IRQ_STAT);
        chk("started", 8'h02, d & 8'h02);
        wake <= 1'b1;
        @(posedge core_clk);
        wake <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 chk("wake hold", 1'b0, run_en);
        wait_run(4700);
        rst(3'h2, 1'b0, 1'b1);
        osc_on(4800);
        rd_reg(SCSS_OFS_CTRL);
        chk("on external", 1'b1, d[3]);
        ext_run <= 1'b0;
        repeat (3500) @(posedge core_clk);
        rd_reg(SCSS_OFS_IRQ_STAT);
        chk("no loss yet", 1'b0, d[0]);
        repeat (1200) @(posedge core_clk);
        rd_reg(SCSS_OFS_IRQ_STAT);
        chk("loss", 1'b1, d[0]);
        rd_reg(SCSS_OFS_CTRL);
        chk("on internal", 1'b0, d[3]);
        chk("run after loss", 1'b1, run_en);
        wrap_up();
    end
endmodule : tb_system_clock_source_select

`default_nettype wire
